// >>> core/pbl_pkg.sv
// Purpose: Shared constants and state type of the self-test, loopback and status block
// Assumes: 16-bit management registers, 5-bit register address
// Notes: Offsets are register indices on the plain register port
`default_nettype none
package pbl_pkg;
  // ==========================================================
  // Register port
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] OFF_TALLY = 5'h15;
  localparam logic [4:0] OFF_CTRL = 5'h16;
  localparam logic [4:0] OFF_STAT = 5'h17;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h1B;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h1C;
  // ==========================================================
  // Reset values and masks
  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam logic [15:0] TALLY_MAX = 16'hFFFF;
  localparam logic [15:0] TALLY_ONE = 16'h0001;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'hF3FF;
  localparam logic [15:0] STAT_RESET = 16'h0040;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // ==========================================================
  // Control fields
  localparam int GEN_LSB = 12;
  localparam int GEN_MSB = 15;
  localparam int RXF_BIT = 7;
  localparam int TXF_BIT = 6;
  localparam int SEL_LSB = 2;
  localparam int SEL_MSB = 5;
  localparam int PCS_LSB = 0;
  localparam int PCS_MSB = 1;
  localparam logic [3:0] GEN_OFF = 4'h0;
  localparam logic [3:0] GEN_CONT = 4'hF;
  localparam logic [3:0] LOOP_NONE = 4'h0;
  localparam logic [3:0] LOOP_DIG = 4'h1;
  localparam logic [3:0] LOOP_ANA = 4'h2;
  localparam logic [3:0] LOOP_EXT = 4'h4;
  localparam logic [3:0] LOOP_REV = 4'h8;
  localparam logic [1:0] PCS_OFF = 2'h0;
  localparam logic [1:0] PCS_PRE_SCR = 2'h1;
  localparam logic [1:0] PCS_POST_SCR = 2'h2;
  localparam logic [1:0] PCS_POST_MLT3 = 2'h3;
  // ==========================================================
  // Status fields
  localparam int ST_PD_FOUND = 15;
  localparam int ST_NO_SIG = 14;
  localparam int ST_WD = 13;
  localparam int ST_NON_PD = 12;
  localparam int ST_LOCK = 11;
  localparam int ST_SYNC_LOST = 10;
  localparam int ST_BUSY = 9;
  localparam int ST_MST = 8;
  localparam int ST_SLV = 7;
  localparam int ST_PWR = 6;
  // ==========================================================
  // Interrupt bits
  localparam int IRQ_W = 6;
  localparam int IRQ_RX_ERR = 0;
  localparam int IRQ_PD_FOUND = 1;
  localparam int IRQ_NO_SIG = 2;
  localparam int IRQ_WD = 3;
  localparam int IRQ_NON_PD = 4;
  localparam int IRQ_SYNC = 5;
  localparam logic [5:0] IRQ_RESET = 6'h00;

  typedef struct packed {
    logic [15:0] tally;
    logic [15:0] ctrl;
    logic [15:0] stat;
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;
    logic [15:0] rdata;
  } pbl_state_t;
endpackage
`default_nettype wire

// >>> core/pbl_top.sv
// Purpose: Self-test control, loopback point selection, receive error tally and status
// Assumes: All event and status inputs come from core logic on clk_sys_i
// Notes: Register reads answer one cycle later; clear-on-read acts at the read strobe
//
// Contract
// - 16-bit error tally, reset zero, write-one clears
// - Generator off at zero, continuous at Fh
// - Reverse loop: bit gates received packets to MAC
// - MII loop: bit gates looped data to line
// - Loop selector decode, only with PCS loop off
// - Gigabit: PCS low bit loops before DSP
// - Fast Ethernet: three PCS loop points
// - Powered device found flag, clear on read
// - No signal flag, clear on read
// - Detection watchdog flag, clear on read
// - Non powered device flag, clear on read
// - Live pattern checker lock bit
// - Sync loss latched high until read
// - Live packet generator busy bit
// - Master legacy coding read-only bit
// - Slave legacy coding read-only bit
// - Core power bit, resets to one
//
// Design decision made here: the plain strobed port.
`default_nettype none
module pbl_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Events from the datapath
  input wire logic rx_error_event_i,
  input wire logic powered_device_found_i,
  input wire logic powered_device_no_signal_i,
  input wire logic powered_device_watchdog_expired_i,
  input wire logic non_powered_device_found_i,
  input wire logic pattern_checker_sync_lost_i,
  // Live status from the core
  input wire logic pattern_checker_locked_i,
  input wire logic packet_generator_running_i,
  input wire logic gig_master_legacy_coding_i,
  input wire logic gig_slave_legacy_coding_i,
  input wire logic core_power_normal_i,
  // Link speed
  input wire logic link_speed_1000_i,
  input wire logic link_speed_100_i,
  // Self-test and loopback controls
  output logic pattern_generator_run_o,
  output logic loop_digital_o,
  output logic loop_analog_o,
  output logic loop_external_o,
  output logic loop_reverse_o,
  output logic pcs_loop_gig_o,
  output logic pcs_loop_pre_scrambler_o,
  output logic pcs_loop_post_scrambler_o,
  output logic pcs_loop_post_mlt3_o,
  output logic rx_to_mac_en_o,
  output logic tx_to_mdi_en_o,
  // Interrupt
  output logic irq_o
);

  // ==========================================================
  // State
  pbl_pkg::pbl_state_t st_reg;
  pbl_pkg::pbl_state_t st_next;

  logic wr_tally;
  logic wr_ctrl;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic rd_stat;
  logic [3:0] gen_field;
  logic [3:0] sel_field;
  logic [1:0] pcs_field;
  logic pcs_off;
  logic [pbl_pkg::IRQ_W-1:0] irq_event;

  assign wr_tally = reg_wr_i && (reg_addr_i == pbl_pkg::OFF_TALLY);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == pbl_pkg::OFF_CTRL);
  assign wr_irq_stat = reg_wr_i && (reg_addr_i == pbl_pkg::OFF_IRQ_STAT);
  assign wr_irq_mask = reg_wr_i && (reg_addr_i == pbl_pkg::OFF_IRQ_MASK);
  assign rd_stat = reg_rd_i && (reg_addr_i == pbl_pkg::OFF_STAT);

  assign gen_field = st_reg.ctrl[pbl_pkg::GEN_MSB:pbl_pkg::GEN_LSB];
  assign sel_field = st_reg.ctrl[pbl_pkg::SEL_MSB:pbl_pkg::SEL_LSB];
  assign pcs_field = st_reg.ctrl[pbl_pkg::PCS_MSB:pbl_pkg::PCS_LSB];
  assign pcs_off = (pcs_field == pbl_pkg::PCS_OFF);

  always_comb begin
    irq_event = pbl_pkg::IRQ_RESET;
    irq_event[pbl_pkg::IRQ_RX_ERR] = rx_error_event_i;
    irq_event[pbl_pkg::IRQ_PD_FOUND] = powered_device_found_i;
    irq_event[pbl_pkg::IRQ_NO_SIG] = powered_device_no_signal_i;
    irq_event[pbl_pkg::IRQ_WD] = powered_device_watchdog_expired_i;
    irq_event[pbl_pkg::IRQ_NON_PD] = non_powered_device_found_i;
    irq_event[pbl_pkg::IRQ_SYNC] = pattern_checker_sync_lost_i;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] tally_kept;
    tally_kept = st_reg.tally;
    st_next = st_reg;

    if (wr_tally) begin
      tally_kept = st_reg.tally & ~reg_wdata_i;
    end
    if (rx_error_event_i && (tally_kept != pbl_pkg::TALLY_MAX)) begin
      st_next.tally = 16'(tally_kept + pbl_pkg::TALLY_ONE);
    end else begin
      st_next.tally = tally_kept;
    end

    // Reserved bits 11-10 stay zero; all other control bits are plain storage
    if (wr_ctrl) begin
      st_next.ctrl = reg_wdata_i & pbl_pkg::CTRL_WR_MASK;
    end

    // Clear on read, a same-cycle event keeps the flag
    if (rd_stat) begin
      st_next.stat[pbl_pkg::ST_PD_FOUND] = 1'b0;
      st_next.stat[pbl_pkg::ST_NO_SIG] = 1'b0;
      st_next.stat[pbl_pkg::ST_WD] = 1'b0;
      st_next.stat[pbl_pkg::ST_NON_PD] = 1'b0;
      st_next.stat[pbl_pkg::ST_SYNC_LOST] = 1'b0;
    end
    if (powered_device_found_i) begin
      st_next.stat[pbl_pkg::ST_PD_FOUND] = 1'b1;
    end
    if (powered_device_no_signal_i) begin
      st_next.stat[pbl_pkg::ST_NO_SIG] = 1'b1;
    end
    if (powered_device_watchdog_expired_i) begin
      st_next.stat[pbl_pkg::ST_WD] = 1'b1;
    end
    if (non_powered_device_found_i) begin
      st_next.stat[pbl_pkg::ST_NON_PD] = 1'b1;
    end
    if (pattern_checker_sync_lost_i) begin
      st_next.stat[pbl_pkg::ST_SYNC_LOST] = 1'b1;
    end

    st_next.stat[pbl_pkg::ST_LOCK] = pattern_checker_locked_i;
    st_next.stat[pbl_pkg::ST_BUSY] = packet_generator_running_i;
    st_next.stat[pbl_pkg::ST_MST] = gig_master_legacy_coding_i;
    st_next.stat[pbl_pkg::ST_SLV] = gig_slave_legacy_coding_i;
    st_next.stat[pbl_pkg::ST_PWR] = core_power_normal_i;

    // Interrupt status: write-one clear, set wins over clear
    for (int i = 0; i < pbl_pkg::IRQ_W; i++) begin
      if (irq_event[i]) begin
        st_next.irq_stat[i] = 1'b1;
      end else if (wr_irq_stat && reg_wdata_i[i]) begin
        st_next.irq_stat[i] = 1'b0;
      end
    end
    if (wr_irq_mask) begin
      st_next.irq_mask = reg_wdata_i[pbl_pkg::IRQ_W-1:0];
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    st_next.rdata = pbl_pkg::ZERO16;
    if (reg_rd_i) begin
      if (reg_addr_i == pbl_pkg::OFF_TALLY) begin
        st_next.rdata = st_reg.tally;
      end else if (reg_addr_i == pbl_pkg::OFF_CTRL) begin
        st_next.rdata = st_reg.ctrl;
      end else if (reg_addr_i == pbl_pkg::OFF_STAT) begin
        st_next.rdata = st_reg.stat;
      end else if (reg_addr_i == pbl_pkg::OFF_IRQ_STAT) begin
        st_next.rdata = {{(pbl_pkg::DATA_W-pbl_pkg::IRQ_W){1'b0}}, st_reg.irq_stat};
      end else if (reg_addr_i == pbl_pkg::OFF_IRQ_MASK) begin
        st_next.rdata = {{(pbl_pkg::DATA_W-pbl_pkg::IRQ_W){1'b0}}, st_reg.irq_mask};
      end else begin
        st_next.rdata = pbl_pkg::ZERO16;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_reg.tally <= pbl_pkg::TALLY_RESET;
      st_reg.ctrl <= pbl_pkg::CTRL_RESET;
      // Power bit reads one out of reset
      st_reg.stat <= pbl_pkg::STAT_RESET;
      st_reg.irq_stat <= pbl_pkg::IRQ_RESET;
      st_reg.irq_mask <= pbl_pkg::IRQ_RESET;
      st_reg.rdata <= pbl_pkg::ZERO16;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = st_reg.rdata;
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

  // Only the all-ones code runs the generator
  assign pattern_generator_run_o = (gen_field == pbl_pkg::GEN_CONT);

  // Selector ignored unless PCS loop is off; undefined codes mean no loop
  assign loop_digital_o = pcs_off && (sel_field == pbl_pkg::LOOP_DIG);
  assign loop_analog_o = pcs_off && (sel_field == pbl_pkg::LOOP_ANA);
  assign loop_external_o = pcs_off && (sel_field == pbl_pkg::LOOP_EXT);
  assign loop_reverse_o = pcs_off && (sel_field == pbl_pkg::LOOP_REV);

  // Gigabit PCS loop on low bit
  assign pcs_loop_gig_o = link_speed_1000_i && pcs_field[pbl_pkg::PCS_LSB];
  assign pcs_loop_pre_scrambler_o = link_speed_100_i && (pcs_field == pbl_pkg::PCS_PRE_SCR);
  assign pcs_loop_post_scrambler_o = link_speed_100_i && (pcs_field == pbl_pkg::PCS_POST_SCR);
  assign pcs_loop_post_mlt3_o = link_speed_100_i && (pcs_field == pbl_pkg::PCS_POST_MLT3);

  // Forwarding bit only matters in reverse loop, so a stray set bit is harmless
  assign rx_to_mac_en_o = !loop_reverse_o || st_reg.ctrl[pbl_pkg::RXF_BIT];
  // MII loop is the digital loop here
  assign tx_to_mdi_en_o = !loop_digital_o || st_reg.ctrl[pbl_pkg::TXF_BIT];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_tally_count: assert property (
    rx_error_event_i && !wr_tally && (st_reg.tally != pbl_pkg::TALLY_MAX)
    |=> st_reg.tally == 16'($past(st_reg.tally) + pbl_pkg::TALLY_ONE))
    else $error("tally did not advance");

  chk_tally_saturate: assert property (
    rx_error_event_i && !wr_tally && (st_reg.tally == pbl_pkg::TALLY_MAX)
    |=> st_reg.tally == pbl_pkg::TALLY_MAX)
    else $error("tally wrapped");

  chk_tally_clear: assert property (
    wr_tally && !rx_error_event_i |=> st_reg.tally == ($past(st_reg.tally) & ~$past(reg_wdata_i)))
    else $error("tally write-one clear wrong");

  chk_read_latency: assert property (
    reg_rd_i && (reg_addr_i == pbl_pkg::OFF_TALLY) && !reg_wr_i
    |=> reg_rdata_o == $past(st_reg.tally)
    ##1 ($past(reg_rd_i) || reg_rdata_o == pbl_pkg::ZERO16))
    else $error("tally read data wrong");

  chk_gen_start: assert property (
    wr_ctrl && (reg_wdata_i[pbl_pkg::GEN_MSB:pbl_pkg::GEN_LSB] != pbl_pkg::GEN_CONT)
    |=> !pattern_generator_run_o)
    else $error("generator runs on undefined code");

  chk_rev_forward: assert property (
    loop_reverse_o && !st_reg.ctrl[pbl_pkg::RXF_BIT] |-> !rx_to_mac_en_o)
    else $error("received packets leak in reverse loop");

  chk_mii_forward: assert property (
    !loop_digital_o |-> tx_to_mdi_en_o)
    else $error("line blocked outside MII loop");

  chk_sel_gate: assert property (
    !pcs_off |-> !(loop_digital_o || loop_analog_o || loop_external_o || loop_reverse_o))
    else $error("selector active with PCS loop");

  chk_fe_points: assert property (
    link_speed_100_i && wr_ctrl
    && (reg_wdata_i[pbl_pkg::PCS_MSB:pbl_pkg::PCS_LSB] == pbl_pkg::PCS_POST_MLT3)
    ##1 link_speed_100_i |-> pcs_loop_post_mlt3_o && !pcs_loop_pre_scrambler_o)
    else $error("fast Ethernet loop point wrong");

  chk_pd_read_clear: assert property (
    rd_stat && st_reg.stat[pbl_pkg::ST_PD_FOUND] && !powered_device_found_i
    |=> reg_rdata_o[pbl_pkg::ST_PD_FOUND] && !st_reg.stat[pbl_pkg::ST_PD_FOUND])
    else $error("found flag not cleared by read");

  chk_sync_hold: assert property (
    pattern_checker_sync_lost_i ##1 !rd_stat |=> st_reg.stat[pbl_pkg::ST_SYNC_LOST])
    else $error("sync loss not held");

  chk_irq_raise: assert property (
    |(irq_event & st_reg.irq_mask) && !wr_irq_mask |=> irq_o)
    else $error("unmasked event did not raise interrupt");

  chk_irq_clear: assert property (
    wr_irq_stat && (irq_event == pbl_pkg::IRQ_RESET)
    |=> (st_reg.irq_stat & $past(reg_wdata_i[pbl_pkg::IRQ_W-1:0])) == pbl_pkg::IRQ_RESET)
    else $error("interrupt status write-one clear wrong");

  chk_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == pbl_pkg::ZERO16)
    else $error("read data stands without a read");

  // ==========================================================
  // Control decode checks
  chk_gen_run: assert property (
    wr_ctrl |=> pattern_generator_run_o
    == ($past(reg_wdata_i[pbl_pkg::GEN_MSB:pbl_pkg::GEN_LSB]) == pbl_pkg::GEN_CONT))
    else $error("generator run does not follow its code");

  chk_digital_sel: assert property (
    wr_ctrl && (reg_wdata_i[pbl_pkg::SEL_MSB:pbl_pkg::SEL_LSB] == pbl_pkg::LOOP_DIG)
    && (reg_wdata_i[pbl_pkg::PCS_MSB:pbl_pkg::PCS_LSB] == pbl_pkg::PCS_OFF)
    |=> loop_digital_o && !loop_analog_o && !loop_external_o && !loop_reverse_o)
    else $error("digital loop not selected");

  chk_rx_forward_set: assert property (
    loop_reverse_o && st_reg.ctrl[pbl_pkg::RXF_BIT] |-> rx_to_mac_en_o)
    else $error("received packets held back despite forwarding");

  chk_mii_block: assert property (
    loop_digital_o && !st_reg.ctrl[pbl_pkg::TXF_BIT] |-> !tx_to_mdi_en_o)
    else $error("looped data leaks to line in MII loop");

  chk_gig_loop: assert property (
    link_speed_1000_i && wr_ctrl && reg_wdata_i[pbl_pkg::PCS_LSB]
    ##1 link_speed_1000_i |-> pcs_loop_gig_o)
    else $error("gigabit PCS loop not taken");

  chk_fe_pre: assert property (
    link_speed_100_i && wr_ctrl
    && (reg_wdata_i[pbl_pkg::PCS_MSB:pbl_pkg::PCS_LSB] == pbl_pkg::PCS_PRE_SCR)
    ##1 link_speed_100_i |-> pcs_loop_pre_scrambler_o && !pcs_loop_post_scrambler_o)
    else $error("fast Ethernet pre-scrambler loop wrong");

  // ==========================================================
  // Status checks
  chk_no_sig_clear: assert property (
    rd_stat && st_reg.stat[pbl_pkg::ST_NO_SIG] && !powered_device_no_signal_i
    |=> reg_rdata_o[pbl_pkg::ST_NO_SIG] && !st_reg.stat[pbl_pkg::ST_NO_SIG])
    else $error("no signal flag not cleared by read");

  chk_no_sig_set: assert property (
    powered_device_no_signal_i |=> st_reg.stat[pbl_pkg::ST_NO_SIG])
    else $error("no signal flag not set");

  chk_wd_set: assert property (
    powered_device_watchdog_expired_i |=> st_reg.stat[pbl_pkg::ST_WD])
    else $error("watchdog flag not set");

  chk_non_pd_set: assert property (
    non_powered_device_found_i |=> st_reg.stat[pbl_pkg::ST_NON_PD])
    else $error("non powered device flag not set");

  chk_sync_clear: assert property (
    rd_stat && !pattern_checker_sync_lost_i |=> !st_reg.stat[pbl_pkg::ST_SYNC_LOST])
    else $error("sync loss not cleared by read");

  chk_lock_live: assert property (
    !sys_rst_i |=> st_reg.stat[pbl_pkg::ST_LOCK] == $past(pattern_checker_locked_i))
    else $error("lock bit does not follow checker");

  chk_busy_live: assert property (
    !sys_rst_i |=> st_reg.stat[pbl_pkg::ST_BUSY] == $past(packet_generator_running_i))
    else $error("busy bit does not follow generator");

  chk_master_live: assert property (
    !sys_rst_i |=> st_reg.stat[pbl_pkg::ST_MST] == $past(gig_master_legacy_coding_i))
    else $error("master coding bit wrong");

  chk_slave_live: assert property (
    !sys_rst_i |=> st_reg.stat[pbl_pkg::ST_SLV] == $past(gig_slave_legacy_coding_i))
    else $error("slave coding bit wrong");

  chk_power_live: assert property (
    !sys_rst_i |=> st_reg.stat[pbl_pkg::ST_PWR] == $past(core_power_normal_i))
    else $error("power bit does not follow core");

endmodule
`default_nettype wire

// >>> testbench/tb_pbl_top.sv
// Purpose: Register-level bench for the self-test, loopback and status block
// Assumes: Read data stand only in the cycle after the read strobe
// Notes: Inputs change by non-blocking assignment at the rising edge
`default_nettype none
module tb_pbl_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rx_err = 1'b0;
  // Sync lost, PD found, no signal, watchdog, non-PD
  logic [4:0] ev = 5'h00;
  // Lock, busy, master legacy, slave legacy, power normal
  logic [4:0] live = 5'h01;
  logic sp1000 = 1'b0;
  logic sp100 = 1'b0;
  logic [15:0] rdata;
  logic run, l_dig, l_ana, l_ext, l_rev, p_gig, p_pre, p_post, p_mlt, rx_en, tx_en, irq;
  int errors = 0;
  int compares = 0;
  int g, s, p, v;

  always #25 clk_sys_i = ~clk_sys_i;

  pbl_top u_pbl_top (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .rx_error_event_i(rx_err),
    .powered_device_found_i(ev[3]), .powered_device_no_signal_i(ev[2]),
    .powered_device_watchdog_expired_i(ev[1]), .non_powered_device_found_i(ev[0]),
    .pattern_checker_sync_lost_i(ev[4]), .pattern_checker_locked_i(live[4]),
    .packet_generator_running_i(live[3]), .gig_master_legacy_coding_i(live[2]),
    .gig_slave_legacy_coding_i(live[1]), .core_power_normal_i(live[0]),
    .link_speed_1000_i(sp1000), .link_speed_100_i(sp100),
    .pattern_generator_run_o(run), .loop_digital_o(l_dig), .loop_analog_o(l_ana),
    .loop_external_o(l_ext), .loop_reverse_o(l_rev), .pcs_loop_gig_o(p_gig),
    .pcs_loop_pre_scrambler_o(p_pre), .pcs_loop_post_scrambler_o(p_post),
    .pcs_loop_post_mlt3_o(p_mlt), .rx_to_mac_en_o(rx_en), .tx_to_mdi_en_o(tx_en),
    .irq_o(irq)
  );

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] want);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(rdata, want);
  endtask

  task automatic fire(input logic [4:0] e, input logic r);
    @(posedge clk_sys_i);
    ev <= e;
    rx_err <= r;
    @(posedge clk_sys_i);
    ev <= 5'h00;
    rx_err <= 1'b0;
    #1;
  endtask

  // Flag must show once, then be gone after that read
  task automatic flag_chk(input logic [4:0] e, input logic [15:0] want);
    fire(e, 1'b0);
    rd_chk(pbl_pkg::OFF_STAT, want);
    rd_chk(pbl_pkg::OFF_STAT, 16'h0040);
  endtask

  task automatic live_chk(input logic [4:0] l, input logic [15:0] want);
    @(posedge clk_sys_i);
    live <= l;
    rd_chk(pbl_pkg::OFF_STAT, want);
  endtask

  task automatic wrap_up;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd_chk(pbl_pkg::OFF_TALLY, 16'h0000);
    rd_chk(pbl_pkg::OFF_CTRL, 16'h0000);
    rd_chk(pbl_pkg::OFF_STAT, 16'h0040);
    chk({13'h0000, rx_en, tx_en, irq}, 16'h0006);
    $display("test reset done");
    repeat (3) fire(5'h00, 1'b1);
    rd_chk(pbl_pkg::OFF_TALLY, 16'h0003);
    wr_reg(pbl_pkg::OFF_TALLY, 16'h0001);
    rd_chk(pbl_pkg::OFF_TALLY, 16'h0002);
    // Long burst must stop at the top instead of wrapping
    @(posedge clk_sys_i);
    rx_err <= 1'b1;
    repeat (65540) @(posedge clk_sys_i);
    rx_err <= 1'b0;
    rd_chk(pbl_pkg::OFF_TALLY, 16'hFFFF);
    wr_reg(pbl_pkg::OFF_TALLY, 16'hFFFF);
    rd_chk(pbl_pkg::OFF_TALLY, 16'h0000);
    $display("test tally done");
    // Reverse loop with forwarding clear holds received packets back; reserved bits 11-10 read back zero
    wr_reg(pbl_pkg::OFF_CTRL, 16'hFF20);
    chk({15'h0000, rx_en}, 16'h0000);
    rd_chk(pbl_pkg::OFF_CTRL, 16'hF320);
    for (g = 0; g < 16; g++) begin
      wr_reg(pbl_pkg::OFF_CTRL, {g[3:0], 12'h000});
      chk({15'h0000, run}, {15'h0000, g == 15});
    end
    for (s = 0; s < 16; s++) begin
      for (p = 0; p < 2; p++) begin
        // Selector is swept with the PCS loop off; with the PCS loop on it is written as zero
        wr_reg(pbl_pkg::OFF_CTRL, {10'h000, ((p == 0) ? s[3:0] : 4'h0), p[1:0]});
        chk({l_dig, l_ana, l_ext, l_rev}, {s == 1 && p == 0, s == 2 && p == 0,
            s == 4 && p == 0, s == 8 && p == 0});
        chk({15'h0000, rx_en}, {15'h0000, !(s == 8 && p == 0)});
        chk({15'h0000, tx_en}, {15'h0000, !(s == 1 && p == 0)});
      end
    end
    wr_reg(pbl_pkg::OFF_CTRL, 16'h00A0);
    chk({15'h0000, rx_en}, 16'h0001);
    wr_reg(pbl_pkg::OFF_CTRL, 16'h0044);
    chk({15'h0000, tx_en}, 16'h0001);
    for (v = 0; v < 4; v++) begin
      @(posedge clk_sys_i);
      sp1000 <= v[1];
      sp100 <= v[0];
      for (p = 0; p < 4; p++) begin
        wr_reg(pbl_pkg::OFF_CTRL, {14'h0000, p[1:0]});
        chk({15'h0000, p_gig}, {15'h0000, v[1] && p[0]});
        chk({p_pre, p_post, p_mlt}, {v[0] && p == 1, v[0] && p == 2, v[0] && p == 3});
      end
    end
    $display("test control done");
    flag_chk(5'h08, 16'h8040);
    flag_chk(5'h04, 16'h4040);
    flag_chk(5'h02, 16'h2040);
    flag_chk(5'h01, 16'h1040);
    flag_chk(5'h10, 16'h0440);
    live_chk(5'h11, 16'h0840);
    live_chk(5'h09, 16'h0240);
    live_chk(5'h04, 16'h0100);
    live_chk(5'h02, 16'h0080);
    live_chk(5'h01, 16'h0040);
    $display("test status done");
    rd_chk(pbl_pkg::OFF_IRQ_STAT, 16'h003F);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(pbl_pkg::OFF_IRQ_MASK, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(pbl_pkg::OFF_IRQ_STAT, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(pbl_pkg::OFF_IRQ_STAT, 16'h003E);
    fire(5'h10, 1'b0);
    chk({15'h0000, irq}, 16'h0000);
    fire(5'h00, 1'b1);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(pbl_pkg::OFF_IRQ_MASK, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    // Unmapped index must neither store nor answer
    wr_reg(5'h00, 16'hFFFF);
    rd_chk(5'h00, 16'h0000);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
